// File: rtl/host_port_pkg.sv
package host_port_pkg;

    // Pin and word widths
    localparam int ADDR_W    = 7;
    localparam int BUS_W     = 16;
    localparam int WORD_W    = 32;
    localparam int QIDX_W    = 5;
    localparam int SYNC_W    = 29;

    // Quadlet indexes of the fifo windows inside the 7-bit byte address space
    localparam logic [4:0] TX_QIDX = 5'h1e;
    localparam logic [4:0] RX_QIDX = 5'h1f;

    // Transmit fifo shape
    localparam int TX_FIFO_DEPTH = 4;

    // Size pin codes, written as {size_sel_hi, size_sel_lo}
    localparam logic [1:0] SZ_CF_4B  = 2'h0;
    localparam logic [1:0] SZ_CF_1B  = 2'h1;
    localparam logic [1:0] SZ_CF_2B  = 2'h2;
    localparam logic [1:0] SZ_CF_16B = 2'h3;

    // Words moved per burst-processor access
    localparam logic [3:0] WORDS_4B  = 4'h2;
    localparam logic [3:0] WORDS_2B  = 4'h1;
    localparam logic [3:0] WORDS_16B = 4'h8;

    // Reset values
    // Bus clock and select start high, so release gives no false edge
    localparam logic [SYNC_W-1:0] SYNC_RST = 29'h1800_0000;
    localparam logic [BUS_W-1:0]  DOUT_RST = 16'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_HS_RD,
        S_HS_WR,
        S_HS_HOLD,
        S_FT_RD,
        S_FT_WR,
        S_CF_RD,
        S_CF_WR
    } state_t;

endpackage

// File: rtl/tx_word_fifo.sv
`timescale 1ns/1ns
module tx_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign o_in_ready  = count != (PW+1)'(DEPTH);
    assign o_out_valid = count != '0;
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule

// File: rtl/host_micro_bus_port.sv
`timescale 1ns/1ns
// How it works
// RL1: Handshake read start drives data lines
// RL2: Handshake read ack follows next edge
// RL3: Select high ends access, releases bus
// RL4: Byte bus uses lines eight to fifteen
// RL5: Line zero is the most significant
// RL6: Handshake write acks at select sample
// RL7: Size pin change gives one-cycle error
// RL8: Bursts only in fixed and processor modes
// RL9: Select low length sets fixed burst
// RL10: Fixed read latches data every edge
// RL11: Fixed read ack delayed two, n long
// RL12: Address only first; then one-cycle transfers
// RL13: Host keeps config bursts within register
// RL14: Fixed write waits one extra cycle
// RL15: Byte writes ignore lines zero to seven
// RL16: Transmit quadlet gathered, then one push
// RL17: Host reads receive fifo whole quadlets
// RL18: Processor mode select low one cycle
// RL19: Processor read enables bus at start
// RL20: Processor mode acks once per word
// RL21: Processor single-byte size is an error
// RL22: Processor write data one cycle later
// RL23: Mode and size pins pick configuration
// RL24: Reads config/rx, writes config/tx only
// RL25: Bus clock edges; reset returns idle
module host_micro_bus_port (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Host bus pins
    input  wire logic        i_host_bus_clk,
    input  wire logic        i_host_select_n,
    input  wire logic        i_write_not_read,
    input  wire logic [6:0]  i_host_addr_bus,
    input  wire logic [0:15] i_host_data_bus,
    output logic      [0:15] o_host_data_bus,
    output logic             o_host_data_oe,
    output logic             o_access_ack_n,
    output logic             o_transfer_error_n,
    input  wire logic        i_size_sel_hi,
    input  wire logic        i_size_sel_lo,
    input  wire logic        i_burst_cpu_mode_pin,
    // Configuration register space
    output logic      [4:0]  o_cfg_rd_idx,
    input  wire logic [31:0] i_cfg_rd_data,
    output logic             o_cfg_wr_en,
    output logic      [4:0]  o_cfg_wr_idx,
    output logic      [31:0] o_cfg_wr_data,
    output logic      [3:0]  o_cfg_wr_strb,
    // Receive fifo
    input  wire logic        i_rx_valid,
    input  wire logic [31:0] i_rx_data,
    output logic             o_rx_pop,
    // Transmit fifo drain
    output logic             o_tx_valid,
    input  wire logic        i_tx_ready,
    output logic      [31:0] o_tx_data
);

    function automatic logic [0:15] get_lane(input logic [31:0] w, input logic [1:0] off, input logic wide);
        logic [7:0] b;
        b = w[8'(31 - 8 * int'(off)) -: 8];
        if (wide) begin
            get_lane = off[1] ? w[15:0] : w[31:16];
        end else begin
            get_lane = {8'h00, b};
        end
    endfunction

    function automatic logic lane_last(input logic [1:0] off, input logic wide);
        lane_last = wide ? off[1] : (off == 2'h3);
    endfunction

    function automatic logic [3:0] lane_strb(input logic [1:0] off, input logic wide);
        if (wide) begin
            lane_strb = off[1] ? 4'h3 : 4'hc;
        end else begin
            lane_strb = 4'h8 >> off;
        end
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [3:0] cf_words(input logic [1:0] sz);
        case (sz)
            host_port_pkg::SZ_CF_4B:  cf_words = host_port_pkg::WORDS_4B;
            host_port_pkg::SZ_CF_2B:  cf_words = host_port_pkg::WORDS_2B;
            host_port_pkg::SZ_CF_16B: cf_words = host_port_pkg::WORDS_16B;
            default:                  cf_words = 4'h0;
        endcase
    endfunction

    // Pin synchroniser and bus clock edge finder
    logic [28:0] sync1;
    logic [28:0] sync2;
    logic        bclk_prev;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1     <= host_port_pkg::SYNC_RST;
            sync2     <= host_port_pkg::SYNC_RST;
            bclk_prev <= 1'b1;
        end else begin
            sync1     <= {i_host_bus_clk, i_host_select_n, i_write_not_read, i_size_sel_hi,
                          i_size_sel_lo, i_burst_cpu_mode_pin, i_host_addr_bus, i_host_data_bus};
            sync2     <= sync1;
            bclk_prev <= sync2[28];
        end
    end

    logic        tick;
    logic        sel_n_s;
    logic        wnr_s;
    logic [1:0]  size_s;
    logic        cf_s;
    logic [6:0]  addr_s;
    logic [0:15] din_s;
    assign tick    = sync2[28] && !bclk_prev; // RL25
    assign sel_n_s = sync2[27];
    assign wnr_s   = sync2[26];
    assign size_s  = sync2[25:24];
    assign cf_s    = sync2[23];
    assign addr_s  = sync2[22:16];
    assign din_s   = sync2[15:0]; // RL5

    host_port_pkg::state_t state;
    logic        wide;
    logic [6:0]  cur_addr;
    logic [1:0]  size_q;
    logic [1:0]  v_pipe;
    logic [0:15] d0;
    logic [0:15] d1;
    logic        pend;
    logic [3:0]  words_left;
    logic        fifo_in_ready;

    // Mode decode at the select sample
    logic start;
    logic start_hs;
    logic start_wide;
    assign start      = tick && state == host_port_pkg::S_IDLE && !sel_n_s;
    assign start_hs   = !cf_s && size_s[1]; // RL23
    assign start_wide = cf_s || !size_s[0]; // RL21

    // Read source for the current address
    logic [6:0]  eff_addr;
    logic        eff_wide;
    logic [31:0] rd_word;
    logic [0:15] rd_lane;
    assign eff_addr     = (state == host_port_pkg::S_IDLE) ? addr_s : cur_addr; // RL12
    assign eff_wide     = (state == host_port_pkg::S_IDLE) ? start_wide : wide;
    assign o_cfg_rd_idx = eff_addr[6:2];
    always_comb begin
        if (eff_addr[6:2] == host_port_pkg::RX_QIDX) begin
            rd_word = i_rx_valid ? i_rx_data : host_port_pkg::WORD_RST;
        end else if (eff_addr[6:2] == host_port_pkg::TX_QIDX) begin
            rd_word = host_port_pkg::WORD_RST;
        end else begin
            rd_word = i_cfg_rd_data; // RL24
        end
    end
    assign rd_lane = get_lane(rd_word, eff_addr[1:0], eff_wide); // RL4

    // Transfer strobes; rd_go and wr_go aligned to a bus clock edge, tx_block and size_chg not
    logic tx_block;
    logic rd_go;
    logic wr_go;
    logic size_chg;
    logic err_now;
    assign tx_block = eff_addr[6:2] == host_port_pkg::TX_QIDX && lane_last(eff_addr[1:0], eff_wide)
                      && !fifo_in_ready;
    assign rd_go    = tick && ((start && wnr_s && !cf_s)
                      || (state == host_port_pkg::S_FT_RD && !sel_n_s)
                      || (state == host_port_pkg::S_CF_RD && words_left != 4'h0));
    assign wr_go    = tick && ((start && !wnr_s && start_hs && !tx_block)
                      || (state == host_port_pkg::S_HS_WR && !sel_n_s && !tx_block)
                      || (state == host_port_pkg::S_FT_WR && pend)
                      || (state == host_port_pkg::S_CF_WR && words_left != 4'h0));
    assign size_chg = state != host_port_pkg::S_IDLE && size_s != size_q;
    assign err_now  = size_chg // RL7
                      || (start && cf_s && size_s == host_port_pkg::SZ_CF_1B) // RL21
                      || (wr_go && tx_block && state != host_port_pkg::S_HS_WR && !(start && start_hs));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_transfer_error_n <= 1'b1;
        end else if (tick) begin
            o_transfer_error_n <= !err_now; // RL7
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur_addr <= '0;
        end else if (rd_go || wr_go) begin
            cur_addr <= eff_addr + (eff_wide ? 7'h2 : 7'h1); // RL12
        end else if (start) begin
            cur_addr <= addr_s;
        end
    end

    // Access sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state           <= host_port_pkg::S_IDLE; // RL25
            o_access_ack_n  <= 1'b1;
            o_host_data_oe  <= 1'b0;
            o_host_data_bus <= host_port_pkg::DOUT_RST;
            wide            <= 1'b1;
            size_q          <= '0;
            v_pipe          <= '0;
            d0              <= host_port_pkg::DOUT_RST;
            d1              <= host_port_pkg::DOUT_RST;
            pend            <= 1'b0;
            words_left      <= '0;
        end else if (tick) begin
            if (size_chg) begin
                size_q <= size_s;
            end
            case (state)
                host_port_pkg::S_IDLE: begin
                    o_access_ack_n <= 1'b1;
                    o_host_data_oe <= 1'b0;
                    if (start) begin
                        size_q <= size_s;
                        wide   <= start_wide;
                        if (cf_s) begin
                            if (size_s != host_port_pkg::SZ_CF_1B) begin
                                words_left     <= cf_words(size_s); // RL20
                                o_host_data_oe <= wnr_s; // RL19
                                state          <= wnr_s ? host_port_pkg::S_CF_RD : host_port_pkg::S_CF_WR;
                            end
                        end else if (start_hs) begin
                            if (wnr_s) begin
                                o_host_data_oe  <= 1'b1; // RL1
                                o_host_data_bus <= rd_lane;
                                state           <= host_port_pkg::S_HS_RD;
                            end else if (tx_block) begin
                                state <= host_port_pkg::S_HS_WR;
                            end else begin
                                o_access_ack_n <= 1'b0; // RL6
                                state          <= host_port_pkg::S_HS_HOLD;
                            end
                        end else if (wnr_s) begin
                            o_host_data_oe  <= 1'b1;
                            o_host_data_bus <= rd_lane; // RL10
                            d0              <= rd_lane;
                            v_pipe          <= 2'h1;
                            state           <= host_port_pkg::S_FT_RD;
                        end else begin
                            pend  <= 1'b1; // RL14
                            state <= host_port_pkg::S_FT_WR;
                        end
                    end
                end
                host_port_pkg::S_HS_RD: begin
                    if (sel_n_s) begin
                        o_access_ack_n <= 1'b1; // RL3
                        o_host_data_oe <= 1'b0;
                        state          <= host_port_pkg::S_IDLE; // RL8
                    end else begin
                        o_access_ack_n <= 1'b0; // RL2
                    end
                end
                host_port_pkg::S_HS_WR: begin
                    if (sel_n_s) begin
                        state <= host_port_pkg::S_IDLE;
                    end else if (!tx_block) begin
                        o_access_ack_n <= 1'b0; // RL6
                        state          <= host_port_pkg::S_HS_HOLD;
                    end
                end
                host_port_pkg::S_HS_HOLD: begin
                    if (sel_n_s) begin
                        o_access_ack_n <= 1'b1; // RL3
                        state          <= host_port_pkg::S_IDLE;
                    end
                end
                host_port_pkg::S_FT_RD: begin
                    v_pipe <= {v_pipe[0], !sel_n_s}; // RL9
                    d1     <= d0;
                    if (!sel_n_s) begin
                        d0 <= rd_lane; // RL10
                    end
                    o_access_ack_n <= !v_pipe[1]; // RL11
                    if (v_pipe[1]) begin
                        o_host_data_bus <= d1;
                    end
                    if (v_pipe == 2'h0 && sel_n_s) begin
                        o_access_ack_n <= 1'b1;
                        o_host_data_oe <= 1'b0;
                        state          <= host_port_pkg::S_IDLE;
                    end
                end
                host_port_pkg::S_FT_WR: begin
                    o_access_ack_n <= !pend; // RL14
                    pend           <= !sel_n_s; // RL9
                    if (!pend && sel_n_s) begin
                        state <= host_port_pkg::S_IDLE;
                    end
                end
                host_port_pkg::S_CF_RD, host_port_pkg::S_CF_WR: begin
                    if (words_left != 4'h0) begin
                        o_access_ack_n <= 1'b0; // RL20
                        words_left     <= words_left - 4'h1;
                        if (state == host_port_pkg::S_CF_RD) begin
                            o_host_data_bus <= rd_lane;
                        end
                    end else begin
                        o_access_ack_n <= 1'b1;
                        o_host_data_oe <= 1'b0;
                        state          <= host_port_pkg::S_IDLE;
                    end
                end
                default: begin
                    state <= host_port_pkg::S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_pop <= 1'b0;
        end else begin
            o_rx_pop <= rd_go && eff_addr[6:2] == host_port_pkg::RX_QIDX && i_rx_valid
                        && lane_last(eff_addr[1:0], eff_wide);
        end
    end

    // Captured write lane
    logic        wr_pulse;
    logic [6:0]  wr_addr;
    logic [0:15] wr_din;
    logic        wr_wide;
    logic        wr_tx;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_pulse <= 1'b0;
            wr_addr  <= '0;
            wr_din   <= host_port_pkg::DOUT_RST;
            wr_wide  <= 1'b1;
            wr_tx    <= 1'b0;
        end else begin
            wr_pulse <= wr_go && !tx_block;
            if (wr_go) begin
                wr_addr <= eff_addr;
                wr_din  <= eff_wide ? din_s : {8'h00, din_s[8:15]}; // RL15
                wr_wide <= eff_wide;
                wr_tx   <= eff_addr[6:2] == host_port_pkg::TX_QIDX;
            end
        end
    end

    logic [3:0]  wr_strb;
    logic [31:0] wr_word;
    assign wr_strb = lane_strb(wr_addr[1:0], wr_wide);
    assign wr_word = wr_wide ? {wr_din, wr_din} : {4{wr_din[8:15]}};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cfg_wr_en   <= 1'b0;
            o_cfg_wr_idx  <= '0;
            o_cfg_wr_data <= host_port_pkg::WORD_RST;
            o_cfg_wr_strb <= '0;
        end else begin
            o_cfg_wr_en <= wr_pulse && !wr_tx && wr_addr[6:2] != host_port_pkg::RX_QIDX; // RL24
            if (wr_pulse) begin
                o_cfg_wr_idx  <= wr_addr[6:2];
                o_cfg_wr_data <= wr_word;
                o_cfg_wr_strb <= wr_strb;
            end
        end
    end

    // Transmit quadlet gathering
    logic [31:0] tx_hold;
    logic [31:0] tx_merged;
    logic        push_v;
    logic [31:0] push_d;
    assign tx_merged = (tx_hold & ~strb_mask(wr_strb)) | (wr_word & strb_mask(wr_strb));
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_hold <= host_port_pkg::WORD_RST;
            push_v  <= 1'b0;
            push_d  <= host_port_pkg::WORD_RST;
        end else begin
            push_v <= wr_pulse && wr_tx && lane_last(wr_addr[1:0], wr_wide); // RL16
            if (wr_pulse && wr_tx) begin
                tx_hold <= tx_merged;
                push_d  <= tx_merged;
            end
        end
    end

    tx_word_fifo #(
        .WIDTH (host_port_pkg::WORD_W),
        .DEPTH (host_port_pkg::TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (push_v),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_d),
        .o_out_valid (o_tx_valid),
        .i_out_ready (i_tx_ready),
        .o_out_data  (o_tx_data)
    );

    hs_rd_drive_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL1
        start && start_hs && wnr_s |=> o_host_data_oe && o_access_ack_n)
        else $error("handshake read did not drive data");
    hs_rd_ack_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL2
        tick && state == host_port_pkg::S_HS_RD && !sel_n_s |=> !o_access_ack_n && o_host_data_oe)
        else $error("handshake read ack missing");
    hs_end_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL3
        tick && sel_n_s && (state == host_port_pkg::S_HS_RD || state == host_port_pkg::S_HS_HOLD)
        |=> o_access_ack_n && !o_host_data_oe && state == host_port_pkg::S_IDLE)
        else $error("handshake end not released");
    byte_lanes_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL4
        o_host_data_oe && !wide && state != host_port_pkg::S_IDLE |-> o_host_data_bus[0:7] == 8'h00)
        else $error("byte bus drove upper lines");
    hs_wr_ack_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL6
        start && start_hs && !wnr_s && !tx_block |=> (!o_access_ack_n) [*4])
        else $error("handshake write ack late");
    size_err_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL7
        tick && size_chg |=> !o_transfer_error_n)
        else $error("size change not flagged");
    err_once_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL7
        tick && !o_transfer_error_n && !err_now |=> o_transfer_error_n)
        else $error("error strobe too long");
    ft_rd_ack_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL11
        tick && state == host_port_pkg::S_FT_RD && v_pipe[1] |=> !o_access_ack_n && o_host_data_bus == $past(d1))
        else $error("fixed read ack or data wrong");
    ft_wr_wait_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL14
        start && !cf_s && !start_hs && !wnr_s |=> o_access_ack_n && pend)
        else $error("fixed write skipped wait");
    cf_burst_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL20
        tick && state == host_port_pkg::S_CF_RD && words_left != 4'h0 |=> !o_access_ack_n)
        else $error("burst word not acked");
    cf_byte_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL21
        start && cf_s && size_s == host_port_pkg::SZ_CF_1B
        |=> !o_transfer_error_n && state == host_port_pkg::S_IDLE && !o_host_data_oe)
        else $error("single byte size accepted");
    rst_idle_a: assert property (@(posedge i_clk) disable iff (i_rst) // RL25
        $fell(i_rst) |-> o_access_ack_n && !o_host_data_oe && o_transfer_error_n)
        else $error("reset left bus active");

    hs_read_c: cover property (@(posedge i_clk) disable iff (i_rst) start && start_hs && wnr_s);
    ft_burst_c: cover property (@(posedge i_clk) disable iff (i_rst) v_pipe == 2'h3);
    cf_16b_c: cover property (@(posedge i_clk) disable iff (i_rst) words_left == host_port_pkg::WORDS_16B);
    err_c: cover property (@(posedge i_clk) disable iff (i_rst) !o_transfer_error_n);

endmodule

// File: sim/host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model (
    input  wire logic        i_clk,
    input  wire logic        i_ack_n,
    input  wire logic        i_err_n,
    input  wire logic [0:15] i_rd,
    output logic             o_bclk,
    output logic             o_sel_n,
    output logic             o_wnr,
    output logic [6:0]       o_addr,
    output logic [0:15]      o_wd,
    output logic [2:0]       o_pins
);
    int chg_at = 0;
    initial begin
        {o_bclk, o_sel_n, o_wnr, o_addr, o_wd, o_pins} = {3'h3, 23'h0, 3'h2};
        #3;
        forever #40 o_bclk = ~o_bclk;
    end
    // Pins settle one edge ahead; select then held per mode
    task automatic xfer(input logic [2:0] p, input logic w, input logic [6:0] a, input logic [0:15] d,
                        input int n, output int acks, output int first, output int errs, output logic [0:15] rd);
        {acks, first, errs, rd} = {32'h0, 32'h0, 32'h0, 16'h0};
        @(posedge o_bclk);
        @(posedge i_clk);
        o_pins <= p;
        @(posedge o_bclk);
        @(posedge i_clk);
        {o_wnr, o_addr, o_wd, o_sel_n} <= {w, a, d, 1'b0};
        for (int i = 1; i < 15; i++) begin
            @(posedge o_bclk);
            errs += (i_err_n === 1'b0);
            if (i_ack_n === 1'b0) begin
                acks++;
                rd = i_rd;
                first = (first == 0) ? i : first;
            end
            @(posedge i_clk);
            o_sel_n <= (p[2:1] == 2'h1) ? (acks > 0) : (i >= n);
            if (i == chg_at) o_pins <= p ^ 3'h1;
        end
    endtask
endmodule

// File: sim/host_micro_bus_port_tb_top.sv
`timescale 1ns/1ns
module host_micro_bus_port_tb_top;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        bclk, sel_n, wnr, oe, ack_n, err_n, tx_valid;
    logic        tx_ready = 1'b0;
    logic [6:0]  addr;
    logic [0:15] wd, rdat, got;
    logic [2:0]  pins;
    logic [4:0]  idx;
    logic [31:0] tx_data;
    int          bad_count = 0, compares = 0, acks, first, errs;
    logic        wr_en, rx_pop, rx_valid = 1'b0;
    logic [4:0]  wr_idx;
    logic [3:0]  wr_strb;
    logic [8:0]  wr_tag;
    logic [31:0] wr_data, wr_seen;
    int          pops = 0;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (wr_en === 1'b1) {wr_tag, wr_seen} <= {wr_idx, wr_strb, wr_data};
        if (rx_pop === 1'b1) pops <= pops + 1;
    end
    host_micro_bus_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_host_bus_clk(bclk), .i_host_select_n(sel_n),
        .i_write_not_read(wnr), .i_host_addr_bus(addr), .i_host_data_bus(wd), .o_host_data_bus(rdat),
        .o_host_data_oe(oe), .o_access_ack_n(ack_n), .o_transfer_error_n(err_n), .i_size_sel_hi(pins[1]),
        .i_size_sel_lo(pins[0]), .i_burst_cpu_mode_pin(pins[2]), .o_cfg_rd_idx(idx),
        .i_cfg_rd_data({3'h0, idx, 24'h5a3c96}), .o_cfg_wr_en(wr_en), .o_cfg_wr_idx(wr_idx),
        .o_cfg_wr_data(wr_data), .o_cfg_wr_strb(wr_strb), .i_rx_valid(rx_valid), .i_rx_data(32'h8e71_d24b),
        .o_rx_pop(rx_pop), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_data(tx_data));
    host_bus_model host_u (.i_clk(i_clk), .i_ack_n(ack_n), .i_err_n(err_n), .i_rd(oe ? rdat : ~rdat),
        .o_bclk(bclk), .o_sel_n(sel_n), .o_wnr(wnr), .o_addr(addr), .o_wd(wd), .o_pins(pins));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic hs_tests;
        host_u.xfer(3'h2, 1'b1, 7'h04, 16'h0, 1, acks, first, errs, got);
        check(got, 32'h015a);
        check(first, 32'h3);
        check(oe, 1'b0);
        host_u.xfer(3'h3, 1'b1, 7'h05, 16'h0, 1, acks, first, errs, got);
        check(got, 32'h005a);
        host_u.xfer(3'h2, 1'b0, 7'h08, 16'h1234, 1, acks, first, errs, got);
        check(first, 32'h2);
        check(wr_seen, 32'h1234_1234);
        check(wr_tag, 32'h2c);
    endtask
    task automatic ft_tests;
        host_u.xfer(3'h0, 1'b1, 7'h04, 16'h0, 2, acks, first, errs, got);
        check({acks[15:0], first[7:0], errs[7:0]}, 32'h0002_0400);
        check(got, 32'h3c96);
        host_u.xfer(3'h0, 1'b0, 7'h78, 16'hc3a5, 2, acks, first, errs, got);
        check({acks[15:0], first[15:0]}, 32'h0002_0003);
        check(tx_valid, 1'b1);
        check(tx_data, 32'hc3a5_c3a5);
        tx_ready <= 1'b1;
        repeat (3) @(posedge i_clk);
        check(tx_valid, 1'b0);
        rx_valid <= 1'b1;
        host_u.xfer(3'h0, 1'b1, 7'h7c, 16'h0, 2, acks, first, errs, got);
        check(got, 32'hd24b);
        check(pops, 32'h1);
        host_u.chg_at = 2;
        host_u.xfer(3'h0, 1'b1, 7'h04, 16'h0, 2, acks, first, errs, got);
        host_u.chg_at = 0;
        check({acks[7:0], errs[7:0]}, 32'h0201);
    endtask
    task automatic cf_tests;
        for (int k = 0; k < 3; k++) begin
            host_u.xfer({1'b1, (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : 2'h3}, 1'b1, 7'h04, 16'h0, 1, acks, first,
                errs, got);
            check({acks[7:0], errs[7:0]}, (k == 0) ? 32'h0200 : (k == 1) ? 32'h0100 : 32'h0800);
            check(got, (k == 1) ? 32'h015a : 32'h3c96);
        end
        host_u.xfer(3'h5, 1'b1, 7'h04, 16'h0, 1, acks, first, errs, got);
        check({acks[7:0], errs[7:0]}, 32'h0001);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        hs_tests();
        ft_tests();
        cf_tests();
        end_sim();
    end
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule
